// File: hw/fcs_host.sv
`timescale 1ns/1ps
module fcs_host
    import fcs_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYC_DEF,
    parameter int unsigned GAP_CYC_P   = GAP_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic chargeStart,
    input  wire logic chargeAbort,
    input  wire logic flashFire,
    input  wire logic flashPermit,
    input  wire logic chargeDoneNIn,
    output logic      chargeRequest,
    output logic      flashFireOut,
    output logic      flashPermitOut,
    output logic      charging,
    output logic      chargeDone,
    output logic      chargeFault
);
    logic             doneNMeta_ff;
    logic             doneNSync_ff;
    logic             nxt_doneNMeta;
    logic             nxt_doneNSync;
    logic             fire_ff;
    logic             permit_ff;
    logic             nxt_fire;
    logic             nxt_permit;
    fcs_state_t       state_ff;
    fcs_state_t       nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             req_ff;
    logic             nxt_req;
    logic             chg_ff;
    logic             nxt_chg;
    logic             done_ff;
    logic             nxt_done;
    logic             fault_ff;
    logic             nxt_fault;

    // in done or trip either user level acknowledges the stop
    function automatic logic ackSeen(input logic startLvl,
                                     input logic abortLvl);
        return startLvl || abortLvl;
    endfunction : ackSeen

    // one compare serves both the charge timeout and the release gap
    function automatic logic cntReached(input logic [CNT_W-1:0] cntVal,
                                        input logic [CNT_W-1:0] limitVal);
        return cntVal >= limitVal;
    endfunction : cntReached

    // done pin is open drain with a pull-up; two flops guard against
    // metastability and only the second one feeds any logic
    always_comb begin
        nxt_doneNMeta = chargeDoneNIn;
        nxt_doneNSync = doneNMeta_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            doneNMeta_ff <= DONE_PIN_IDLE;
            doneNSync_ff <= DONE_PIN_IDLE;
        end else begin
            doneNMeta_ff <= nxt_doneNMeta;
            doneNSync_ff <= nxt_doneNSync;
        end
    end

    // both levels registered so the pins come straight from flops; this
    // spends one clock of the gate latency budget [R13] [R15]
    always_comb begin
        nxt_fire   = flashFire;
        nxt_permit = flashPermit;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fire_ff   <= 1'h0;
            permit_ff <= 1'h0;
        end else begin
            fire_ff   <= nxt_fire;
            permit_ff <= nxt_permit;
        end
    end

    // charge timer and release gap share one counter; it restarts at
    // every phase change except into done or trip, so no stale count leaks into a timed phase
    always_comb begin
        nxt_cnt = cnt_ff;
        case (state_ff)
            FCS_IDLE: begin
                nxt_cnt = '0;
            end
            FCS_CHARGE: begin
                // counts from the cycle the request rises [R12]
                if (chargeAbort) begin
                    nxt_cnt = '0;
                end else begin
                    nxt_cnt = cnt_ff + CNT_W'(1);
                end
            end
            FCS_DONE: begin
                if (ackSeen(chargeStart, chargeAbort)) begin
                    nxt_cnt = '0;
                end
            end
            FCS_TRIP: begin
                if (ackSeen(chargeStart, chargeAbort)) begin
                    nxt_cnt = '0;
                end
            end
            FCS_RELEASE: begin
                if (cntReached(cnt_ff, CNT_W'(GAP_CYC_P))) begin
                    nxt_cnt = '0;
                end else begin
                    nxt_cnt = cnt_ff + CNT_W'(1);
                end
            end
            default: begin
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_req   = req_ff;
        nxt_chg   = chg_ff;
        nxt_done  = done_ff;
        nxt_fault = fault_ff;
        case (state_ff)
            FCS_IDLE: begin
                // abort wins so a held abort can never start a charge
                if (chargeStart && !chargeAbort) begin
                    nxt_req   = 1'h1; // [R01] [R07]
                    nxt_chg   = 1'h1;
                    nxt_done  = 1'h0;
                    nxt_fault = 1'h0;
                    nxt_state = FCS_CHARGE;
                end
            end
            FCS_CHARGE: begin
                if (chargeAbort) begin
                    nxt_req   = 1'h0; // [R04]
                    nxt_chg   = 1'h0;
                    nxt_state = FCS_RELEASE;
                end else if (!doneNSync_ff) begin
                    // device stopped itself at full charge [R05] [R08] [R17]
                    nxt_chg   = 1'h0;
                    nxt_done  = 1'h1;
                    nxt_state = FCS_DONE;
                end else if (cntReached(cnt_ff, CNT_W'(TIMEOUT_CYC))) begin
                    // no done in time: assume latched trip [R12] [R06] [R11]
                    nxt_chg   = 1'h0;
                    nxt_fault = 1'h1;
                    nxt_state = FCS_TRIP;
                end
            end
            FCS_DONE: begin
                // done holds until the release gap after the request drop ends [R10]
                if (ackSeen(chargeStart, chargeAbort)) begin
                    nxt_req   = 1'h0; // [R10]
                    nxt_state = FCS_RELEASE;
                end
            end
            FCS_TRIP: begin
                // only a drop of request recovers a trip [R19] [R20]
                if (ackSeen(chargeStart, chargeAbort)) begin
                    nxt_req   = 1'h0; // [R19]
                    nxt_state = FCS_RELEASE;
                end
            end
            FCS_RELEASE: begin
                // low long enough for the device to see it; an overtemp
                // latch may still hold if the die is hot [R20]
                if (cntReached(cnt_ff, CNT_W'(GAP_CYC_P))) begin
                    nxt_done  = 1'h0;
                    nxt_state = FCS_IDLE;
                end
            end
            default: begin
                nxt_req   = 1'h0;
                nxt_chg   = 1'h0;
                nxt_state = FCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_ff <= FCS_IDLE;
            req_ff   <= 1'h0;
            chg_ff   <= 1'h0;
            done_ff  <= 1'h0;
            fault_ff <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            req_ff   <= nxt_req;
            chg_ff   <= nxt_chg;
            done_ff  <= nxt_done;
            fault_ff <= nxt_fault;
        end
    end

    assign chargeRequest  = req_ff;
    assign flashFireOut   = fire_ff;
    assign flashPermitOut = permit_ff;
    assign charging       = chg_ff;
    assign chargeDone     = done_ff;
    assign chargeFault    = fault_ff;
endmodule : fcs_host

// File: hw/fcs_pkg.sv
// Contract
// R01: only a raised request starts charging
// R02: device latches the request level
// R03: run follows request after 50us typ, 150us max
// R04: dropping request forces a stop
// R05: device stops itself at full charge
// R06: device stops on overcurrent trip
// R07: raising request again restarts after forced stop
// R08: done pin only pulled low at full charge
// R09: done pin released while charging or faulted
// R10: only dropping request clears done
// R11: after overcurrent, done stays released
// R12: host times charge; timeout means overcurrent
// R13: gate on only when fire and permit high
// R14: source pin turns on, sink pin turns off
// R15: gate follows inputs in about 25ns
// R16: switch turns off at current limit
// R17: full charge clears run, device disables
// R18: switch turns on at zero crossing
// R19: overcurrent latches off until request drops
// R20: overtemp latches off until cool and request drops
// R21: switch held off while run is low
package fcs_pkg;
    localparam int unsigned CLK_PERIOD_PS      = 4000;
    localparam int unsigned REQ_DELAY_MAX_US   = 150;
    localparam int unsigned MAX_CHARGE_MS      = 2000;
    localparam int unsigned RESTART_GAP_US     = 200;
    localparam int unsigned CYC_PER_US         = 1000000 / CLK_PERIOD_PS;
    localparam int unsigned DONE_WAIT_CYC      =
        REQ_DELAY_MAX_US * CYC_PER_US;
    localparam int unsigned GAP_CYC            = RESTART_GAP_US * CYC_PER_US;
    localparam int unsigned TIMEOUT_CYC_DEF    = MAX_CHARGE_MS * 1000 *
        CYC_PER_US;
    localparam int unsigned CNT_W              = 32;
    // released open-drain pin reads high through its pull-up
    localparam logic        DONE_PIN_IDLE      = 1'h1;

    typedef enum logic [2:0] {
        FCS_IDLE    = 3'b000,
        FCS_CHARGE  = 3'b001,
        FCS_DONE    = 3'b010,
        FCS_TRIP    = 3'b011,
        FCS_RELEASE = 3'b100
    } fcs_state_t;
endpackage : fcs_pkg

// File: tb/fcs_host_chk.sv
`timescale 1ns/1ps
module fcs_host_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic chargeStart,
    input wire logic chargeAbort,
    input wire logic chargeDoneNIn,
    input wire logic chargeRequest,
    input wire logic charging,
    input wire logic chargeDone,
    input wire logic chargeFault
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // gap must outlast the device noise filter
    sequence relGap; !chargeRequest [*8]; endsequence
    req_start_a: assert property ($rose(chargeRequest) |->
        $past(chargeStart) && !$past(chargeAbort)) else $error("bad start");
    abort_stop_a: assert property (charging && chargeAbort |=>
        !chargeRequest) else $error("abort ignored");
    gap_hold_a: assert property ($fell(chargeRequest) |=> relGap)
        else $error("gap short");
    done_clear_a: assert property ($fell(chargeDone) |->
        !chargeRequest) else $error("done cleared early");
    trip_ack_a: assert property (chargeFault && chargeRequest &&
        chargeStart |=> !chargeRequest) else $error("no release");
    fault_time_a: assert property ($rose(chargeFault) |->
        $past(charging) && !charging) else $error("bad fault");
    done_seen_a: assert property ($fell(chargeDoneNIn) && charging
        |-> ##[1:4] chargeDone) else $error("done missed");
endmodule : fcs_host_chk

// File: tb/fcs_dev_model.sv
`timescale 1ns/1ps
module fcs_dev_model #(parameter int DLY = 10, parameter int CHARGE_REQUEST = 50) (
    input wire logic clk_sys,
    input wire logic chargeRequest,
    input wire logic fireIn,
    input wire logic permitIn,
    input wire logic ocTrip,
    output logic     chargeDoneN,
    output logic     gateOn
);
    int   cnt = 0;
    logic run = 0;
    logic tripped = 0;
    initial chargeDoneN = 1'b1; // pull-up level while released
    assign gateOn = fireIn && permitIn;
    always @(posedge clk_sys) begin
        if (!chargeRequest) begin
            cnt <= 0; run <= 0; tripped <= 0; chargeDoneN <= 1'b1;
        end else if (ocTrip || tripped) begin
            tripped <= 1'b1; run <= 0;
        end else if (chargeDoneN) begin
            cnt <= cnt + 1;
            run <= (cnt >= DLY);
            if (run && cnt == DLY + CHARGE_REQUEST) begin
                chargeDoneN <= 1'b0;
                run <= 0;
            end
        end
    end
endmodule : fcs_dev_model

// File: tb/fcs_host_tb.sv
`timescale 1ns/1ps
module fcs_host_tb;
    logic clk_sys = 0, rst_b = 0, chargeStart = 0, chargeAbort = 0;
    logic flashFire = 0, flashPermit = 0, ocTrip = 0, gateOn;
    logic chargeDoneNIn, chargeRequest, fireO, permitO;
    logic charging, chargeDone, chargeFault;
    int   errTotal = 0, comparisons = 0;
    always #2 clk_sys = ~clk_sys;
    fcs_host #(.TIMEOUT_CYC(1000), .GAP_CYC_P(20)) u_fcs_host (.clk_sys,
        .rst_b, .chargeStart, .chargeAbort, .flashFire, .flashPermit,
        .chargeDoneNIn, .chargeRequest, .flashFireOut(fireO),
        .flashPermitOut(permitO), .charging, .chargeDone, .chargeFault);
    fcs_dev_model u_fcs_dev_model (.clk_sys, .chargeRequest, .fireIn(fireO),
        .permitIn(permitO), .ocTrip, .chargeDoneN(chargeDoneNIn), .gateOn);
    task chk(input logic a, input logic e);
        comparisons++;
        if (a !== e) begin
            errTotal++;
            $display("wrong value %0t got %h exp %h", $time, a, e);
        end
    endtask : chk
    task go(input logic s, input logic a);
        @(posedge clk_sys); chargeStart <= s; chargeAbort <= a;
        @(posedge clk_sys); chargeStart <= 0; chargeAbort <= 0;
        @(posedge clk_sys); #1;
    endtask : go
    task wt;
        for (int i = 0; i < 2000 && chargeDone !== 1 && chargeFault !== 1;
             i++) @(posedge clk_sys);
        #1;
    endtask : wt
    task complete_run;
        $display("errors %0d compares %0d", errTotal, comparisons);
        if (errTotal == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #40000 errTotal++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            flashFire <= k[0];
            flashPermit <= k[1];
            repeat (3) @(posedge clk_sys);
            #1 chk(gateOn, k == 3);
        end
        go(1, 1); chk(chargeRequest, 0);
        go(1, 0); chk(chargeRequest, 1);
        chk(charging, 1);
        wt(); chk(chargeDone, 1);
        chk(charging, 0);
        repeat (10) @(posedge clk_sys);
        #1 chk(chargeDone, 1);
        go(1, 0); chk(chargeRequest, 0);
        repeat (25) @(posedge clk_sys); #1 chk(chargeDone, 0);
        go(1, 0); repeat (5) @(posedge clk_sys);
        go(0, 1); chk(chargeRequest, 0);
        chk(charging, 0);
        repeat (25) @(posedge clk_sys); go(1, 0);
        wt(); chk(chargeDone, 1);
        go(0, 1); repeat (25) @(posedge clk_sys);
        go(1, 0); repeat (15) @(posedge clk_sys);
        ocTrip <= 1; @(posedge clk_sys); ocTrip <= 0;
        wt(); chk(chargeFault, 1);
        chk(charging, 0);
        chk(chargeDone, 0);
        chk(chargeDoneNIn, 1);
        go(1, 0); chk(chargeRequest, 0);
        repeat (25) @(posedge clk_sys); go(1, 0);
        chk(chargeFault, 0);
        chk(chargeRequest, 1);
        wt(); chk(chargeDone, 1);
        complete_run();
    end
endmodule : fcs_host_tb
bind fcs_host fcs_host_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .chargeStart(chargeStart), .chargeAbort(chargeAbort),
    .chargeDoneNIn(chargeDoneNIn), .chargeRequest(chargeRequest),
    .charging(charging), .chargeDone(chargeDone), .chargeFault(chargeFault));
